// [src/cwu_pkg.sv]
// constants and types for the complementary waveform unit
package cwu_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_MAIN     = 5'h00;
    localparam logic [4:0] OFS_OVERRIDE = 5'h04;
    localparam logic [4:0] OFS_SHUTDOWN = 5'h08;
    localparam logic [4:0] OFS_RISE_DB  = 5'h0C;
    localparam logic [4:0] OFS_FALL_DB  = 5'h10;
    localparam logic [4:0] OFS_STATUS   = 5'h14;
    // main control fields
    localparam int B_UNIT_ENABLE  = 7;
    localparam int B_OUT_B_ENABLE = 6;
    localparam int B_OUT_A_ENABLE = 5;
    localparam int B_OUT_B_INVERT = 4;
    localparam int B_OUT_A_INVERT = 3;
    localparam int B_CLOCK_SELECT = 0;
    // override and source fields
    localparam int B_LVL_B_LO = 6;
    localparam int B_LVL_A_LO = 4;
    localparam int B_SRC_LO   = 0;
    // shutdown control fields
    localparam int B_SHUTDOWN_FLAG = 7;
    localparam int B_AUTO_RESTART  = 6;
    localparam int B_SD_CMP_TWO    = 3;
    localparam int B_SD_CMP_ONE    = 2;
    localparam int B_SD_FAULT      = 1;
    localparam int B_SD_CELL_TWO   = 0;
    // sampled input vector positions; 0..7 equal the source select codes
    localparam int IN_CMP_TWO  = 0;
    localparam int IN_CMP_ONE  = 1;
    localparam int IN_CELL_TWO = 8;
    localparam int IN_FAULT    = 9;
    localparam int IN_WIDTH    = 10;
    // override level encodings
    localparam logic [1:0] OVR_HIGH     = 2'h3;
    localparam logic [1:0] OVR_LOW      = 2'h2;
    localparam logic [1:0] OVR_FLOAT    = 2'h1;
    localparam logic [1:0] OVR_INACTIVE = 2'h0;
    // reset values
    localparam logic [7:0] RST_MAIN     = 8'h00;
    localparam logic [7:0] RST_OVERRIDE = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [5:0] RST_DB       = 6'h00;
    // source activity window in generator ticks, and fast tick divider
    localparam logic [7:0] ACT_SPAN     = 8'hFF;
    localparam int         FAST_DIV_DEF = 2;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_RWAIT  = 3'b001,
        PH_A_ON   = 3'b010,
        PH_FWAIT  = 3'b011,
        PH_B_ON   = 3'b100
    } cwu_phase_t;
endpackage : cwu_pkg

// [src/cwu_top.sv]
// complementary waveform unit with dead band, shutdown and register slave
// Behaviour
// (R1) keeps running during sleep while clocked
// (R2) requests fast oscillator when enabled, selected, active
// (R3) software configures with pins as inputs first
// (R4) software starts via auto-restart or clearing flag
// (R5) shutdown drives override levels, polarity ignored except for the inactive level
// (R6) auto-restart bit chooses software or automatic restart
// (R7) flag clear ignored while enabled source asserted
// (R8) overrides hold until next input rising edge
// (R9) auto-restart clears flag when sources inactive
// (R10) enable bit; disabled unit releases both pins
// (R11) output enable bits release pin when clear
// (R12) polarity bits invert active waveform
// (R13) bit zero selects generator clock tick
// (R14) B override field has four encodings
// (R15) A override field same encodings as B
// (R16) three-bit field selects input source
// (R17) shutdown flag readable, write one forces it
// (R18) comparator shutdown enables, high active
// (R19) fault pin low, logic cell high shutdown
// (R20) shutdown sources level sensed, flag sticks
// (R21) dead band counts ticks up to count value
// (R22) rise: B off now, A after rise band
// (R23) fall: A off now, B after fall band
// (R24) inputs synchronised, one tick uncertainty
// (R25) enable starts with both drives cleared
`timescale 1ns/1ps
`default_nettype none
module cwu_top
    import cwu_pkg::*;
#(
    parameter int FAST_DIV = FAST_DIV_DEF
) (
    input  wire logic        mclk,                      // 25 MHz clock
    input  wire logic        srst,                      // sync reset, high
    input  wire logic [4:0]  avs_address,               // byte address
    input  wire logic        avs_read,                  // read request
    input  wire logic        avs_write,                 // write request
    input  wire logic [31:0] avs_writedata,             // write data
    input  wire logic [3:0]  avs_byteenable,            // byte lanes
    output logic [31:0]      avs_readdata,              // read data
    output logic             avs_waitrequest,           // stall
    input  wire logic        comparator_one_output,     // source / fault
    input  wire logic        comparator_two_output,     // source / fault
    input  wire logic [3:0]  pulse_width_outputs,       // pwm sources 1..4
    input  wire logic        numeric_oscillator_output, // source
    input  wire logic        logic_cell_one_output,     // source
    input  wire logic        logic_cell_two_output,     // fault source
    input  wire logic        external_fault_pin_n,      // fault, low active
    output logic             output_a_o,                // pin A level
    output logic             output_a_oe,               // pin A drive enable
    output logic             output_b_o,                // pin B level
    output logic             output_b_oe,               // pin B drive enable
    output logic             fast_osc_keep              // keep oscillator on
);
    typedef struct packed {
        logic             unit_enable;
        logic             out_b_enable;
        logic             out_a_enable;
        logic             out_b_invert;
        logic             out_a_invert;
        logic             clock_select;
        logic [1:0]       out_b_override_level;
        logic [1:0]       out_a_override_level;
        logic [2:0]       input_source_select;
        logic             shutdown_flag;
        logic             auto_restart_enable;
        logic [3:0]       shutdown_enables;
        logic [5:0]       rising_deadband_count;
        logic [5:0]       falling_deadband_count;
        logic [IN_WIDTH-1:0] sync1;
        logic [IN_WIDTH-1:0] sync2;
        logic             src_prev;
        cwu_phase_t       phase;
        logic [5:0]       cnt;
        logic             hold;
        logic [7:0]       div;
        logic [7:0]       act;
        logic             osc_keep;
        logic             waitreq;
        logic [7:0]       rdata;
        logic             a_o;
        logic             a_oe;
        logic             b_o;
        logic             b_oe;
    } cwu_state_t;

    cwu_state_t state_reg;
    cwu_state_t state_next;

    logic [IN_WIDTH-1:0] raw_in;
    logic                src_now;
    logic                rise_ev;
    logic                fall_ev;
    logic                src_hit;
    logic                ovr_on;
    logic                run_gate;
    logic                tick;
    logic                acc;
    logic                wr_ok;
    logic                sw_set;
    logic                sw_clr;
    logic [7:0]          wd;
    logic [1:0]          pin_a;
    logic [1:0]          pin_b;

    // returns {drive enable, level} for one output pin
    function automatic logic [1:0] pin_drive(input logic en, input logic oe,
                                             input logic ovr, input logic [1:0] lvl,
                                             input logic drv, input logic inv);
        logic [1:0] res;
        res = 2'b00;
        if (en && oe) begin
            if (!ovr) begin
                res = {1'b1, drv ^ inv};
            end else begin
                case (lvl)
                    OVR_HIGH:  res = 2'b11;
                    OVR_LOW:   res = 2'b10;
                    OVR_FLOAT: res = 2'b00;
                    default:   res = {1'b1, inv};
                endcase
            end
        end
        return res;
    endfunction : pin_drive

    assign raw_in = {external_fault_pin_n, logic_cell_two_output, logic_cell_one_output,
                     numeric_oscillator_output, pulse_width_outputs,
                     comparator_one_output, comparator_two_output};

    // only the second sampling stage is read by any logic
    assign src_now = state_reg.sync2[state_reg.input_source_select]; // R16 R24
    assign rise_ev = src_now && !state_reg.src_prev;
    assign fall_ev = !src_now && state_reg.src_prev;
    assign src_hit = (state_reg.shutdown_enables[B_SD_CMP_TWO] && state_reg.sync2[IN_CMP_TWO])
                   | (state_reg.shutdown_enables[B_SD_CMP_ONE] && state_reg.sync2[IN_CMP_ONE])
                   | (state_reg.shutdown_enables[B_SD_FAULT] && !state_reg.sync2[IN_FAULT])
                   | (state_reg.shutdown_enables[B_SD_CELL_TWO]
                      && state_reg.sync2[IN_CELL_TWO]); // R18 R19 R20
    assign ovr_on   = state_reg.shutdown_flag || state_reg.hold;
    // a held override lets the very rising edge that releases it start a cycle
    assign run_gate = state_reg.unit_enable && !state_reg.shutdown_flag
                      && !(state_reg.hold && !rise_ev); // R8 R10
    assign tick     = !state_reg.clock_select || (state_reg.div == 8'h00); // R13 R21
    assign acc      = !state_reg.waitreq;
    assign wr_ok    = acc && avs_write && avs_byteenable[0];
    assign wd       = avs_writedata[7:0];
    assign sw_set   = wr_ok && (avs_address == OFS_SHUTDOWN) && wd[B_SHUTDOWN_FLAG];
    assign sw_clr   = wr_ok && (avs_address == OFS_SHUTDOWN) && !wd[B_SHUTDOWN_FLAG];

    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = raw_in;
        state_next.sync2 = state_reg.sync1;
        state_next.src_prev = src_now;

        // bus slave: one stall cycle, then a one-cycle acknowledge
        state_next.waitreq = !(state_reg.waitreq && (avs_read || avs_write));
        if (state_reg.waitreq) begin
            case (avs_address)
                OFS_MAIN:     state_next.rdata = {state_reg.unit_enable,
                                                  state_reg.out_b_enable,
                                                  state_reg.out_a_enable,
                                                  state_reg.out_b_invert,
                                                  state_reg.out_a_invert, 2'b00,
                                                  state_reg.clock_select}; // R13
                OFS_OVERRIDE: state_next.rdata = {state_reg.out_b_override_level,
                                                  state_reg.out_a_override_level, 1'b0,
                                                  state_reg.input_source_select}; // R15
                OFS_SHUTDOWN: state_next.rdata = {state_reg.shutdown_flag,
                                                  state_reg.auto_restart_enable, 2'b00,
                                                  state_reg.shutdown_enables}; // R17
                OFS_RISE_DB:  state_next.rdata = {2'b00, state_reg.rising_deadband_count};
                OFS_FALL_DB:  state_next.rdata = {2'b00, state_reg.falling_deadband_count};
                OFS_STATUS:   state_next.rdata = {2'b00, state_reg.osc_keep,
                                                  state_reg.phase, state_reg.hold,
                                                  state_reg.src_prev};
                default:      state_next.rdata = 8'h00;
            endcase
        end
        if (wr_ok) begin
            case (avs_address)
                OFS_MAIN: begin
                    state_next.unit_enable  = wd[B_UNIT_ENABLE];  // R10
                    state_next.out_b_enable = wd[B_OUT_B_ENABLE]; // R11
                    state_next.out_a_enable = wd[B_OUT_A_ENABLE]; // R11
                    state_next.out_b_invert = wd[B_OUT_B_INVERT]; // R12
                    state_next.out_a_invert = wd[B_OUT_A_INVERT]; // R12
                    state_next.clock_select = wd[B_CLOCK_SELECT]; // R13
                end
                OFS_OVERRIDE: begin
                    state_next.out_b_override_level = wd[B_LVL_B_LO+:2]; // R14
                    state_next.out_a_override_level = wd[B_LVL_A_LO+:2]; // R15
                    state_next.input_source_select  = wd[B_SRC_LO+:3];   // R16
                end
                OFS_SHUTDOWN: begin
                    state_next.auto_restart_enable = wd[B_AUTO_RESTART]; // R6
                    state_next.shutdown_enables    = wd[3:0];            // R18 R19
                end
                OFS_RISE_DB: state_next.rising_deadband_count  = wd[5:0];
                OFS_FALL_DB: state_next.falling_deadband_count = wd[5:0];
                default: ;
            endcase
        end

        // shutdown flag: any set beats any clear in the same cycle
        if (src_hit || sw_set) begin
            state_next.shutdown_flag = 1'b1; // R17 R20 R7
        end else if (sw_clr || state_reg.auto_restart_enable) begin
            state_next.shutdown_flag = 1'b0; // R6 R9
        end

        // override stays until the first rising edge after the flag drops
        if (state_reg.shutdown_flag) begin
            state_next.hold = 1'b1; // R8
        end else if (rise_ev) begin
            state_next.hold = 1'b0; // R8
        end

        // dead-band tick divider for the fast clock choice
        if (state_reg.div >= 8'(FAST_DIV - 1)) begin
            state_next.div = 8'h00;
        end else begin
            state_next.div = state_reg.div + 8'h01;
        end

        // source activity window for the oscillator keep-alive
        if (rise_ev || fall_ev) begin
            state_next.act = ACT_SPAN;
        end else if (tick && state_reg.act != 8'h00) begin
            state_next.act = state_reg.act - 8'h01;
        end
        // no sleep input gates anything: the unit just runs on its clock
        state_next.osc_keep = state_reg.unit_enable && state_reg.clock_select
                              && (state_reg.act != 8'h00); // R1 R2

        if (!run_gate) begin
            state_next.phase = PH_IDLE; // R25 R5
            state_next.cnt   = 6'h00;
        end else if (rise_ev) begin
            state_next.cnt   = 6'h00; // R22
            state_next.phase = (state_reg.rising_deadband_count == 6'h00) ? PH_A_ON
                                                                         : PH_RWAIT;
        end else if (fall_ev) begin
            state_next.cnt   = 6'h00; // R23
            state_next.phase = (state_reg.falling_deadband_count == 6'h00) ? PH_B_ON
                                                                          : PH_FWAIT;
        end else if (tick) begin
            case (state_reg.phase)
                PH_RWAIT: begin
                    if (state_reg.cnt + 6'h01 == state_reg.rising_deadband_count) begin
                        state_next.phase = PH_A_ON; // R21 R22
                    end else begin
                        state_next.cnt = state_reg.cnt + 6'h01;
                    end
                end
                PH_FWAIT: begin
                    if (state_reg.cnt + 6'h01 == state_reg.falling_deadband_count) begin
                        state_next.phase = PH_B_ON; // R21 R23
                    end else begin
                        state_next.cnt = state_reg.cnt + 6'h01;
                    end
                end
                PH_IDLE, PH_A_ON, PH_B_ON: ;
                default: state_next.phase = PH_IDLE;
            endcase
        end

        pin_a = pin_drive(state_reg.unit_enable, state_reg.out_a_enable, ovr_on,
                          state_reg.out_a_override_level, state_reg.phase == PH_A_ON,
                          state_reg.out_a_invert); // R5 R10 R11 R12 R15
        pin_b = pin_drive(state_reg.unit_enable, state_reg.out_b_enable, ovr_on,
                          state_reg.out_b_override_level, state_reg.phase == PH_B_ON,
                          state_reg.out_b_invert); // R5 R10 R11 R12 R14
        state_next.a_oe = pin_a[1];
        state_next.a_o  = pin_a[0];
        state_next.b_oe = pin_b[1];
        state_next.b_o  = pin_b[0];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= '0;
            state_reg.waitreq <= 1'b1;
            {state_reg.unit_enable, state_reg.out_b_enable, state_reg.out_a_enable,
             state_reg.out_b_invert, state_reg.out_a_invert} <= RST_MAIN[7:3];
            state_reg.clock_select <= RST_MAIN[0];
            {state_reg.out_b_override_level, state_reg.out_a_override_level}
                <= RST_OVERRIDE[7:4];
            state_reg.input_source_select <= RST_OVERRIDE[2:0];
            {state_reg.shutdown_flag, state_reg.auto_restart_enable} <= RST_SHUTDOWN[7:6];
            state_reg.shutdown_enables <= RST_SHUTDOWN[3:0];
            state_reg.rising_deadband_count  <= RST_DB;
            state_reg.falling_deadband_count <= RST_DB;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata    = {24'h00_0000, state_reg.rdata};
    assign avs_waitrequest = state_reg.waitreq;
    assign output_a_o      = state_reg.a_o;
    assign output_a_oe     = state_reg.a_oe;
    assign output_b_o      = state_reg.b_o;
    assign output_b_oe     = state_reg.b_oe;
    assign fast_osc_keep   = state_reg.osc_keep;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence rise_start_s;
        rise_ev && run_gate && !state_reg.clock_select
        && state_reg.rising_deadband_count == 6'h01;
    endsequence
    sequence still_high_s;
        src_now && run_gate && !state_reg.clock_select
        && state_reg.rising_deadband_count == 6'h01;
    endsequence

    disabled_release_a: assert property (!state_reg.unit_enable |=> // R10
        !output_a_oe && !output_b_oe) else $error("disabled unit drives a pin");
    override_high_a: assert property (state_reg.unit_enable && state_reg.out_a_enable // R5
        && state_reg.shutdown_flag && state_reg.out_a_override_level == OVR_HIGH
        |=> output_a_oe && output_a_o) else $error("A override high not driven");
    override_float_a: assert property (state_reg.shutdown_flag // R14
        && state_reg.out_b_override_level == OVR_FLOAT |=> !output_b_oe)
        else $error("B not released under float override");
    clear_blocked_a: assert property (state_reg.shutdown_flag && src_hit && sw_clr // R7
        |=> state_reg.shutdown_flag) else $error("flag cleared with source active");
    auto_restart_a: assert property (state_reg.shutdown_flag // R9
        && state_reg.auto_restart_enable && !src_hit && !sw_set
        |=> !state_reg.shutdown_flag) else $error("auto restart did not clear flag");
    level_sticky_a: assert property (src_hit |=> state_reg.shutdown_flag [*1]) // R20
        else $error("active source did not hold shutdown");
    rise_band_a: assert property (rise_start_s ##1 still_high_s // R22
        |=> state_reg.phase == PH_A_ON) else $error("A not on after one tick band");
    fall_cut_a: assert property (fall_ev && state_reg.unit_enable // R23
        |=> state_reg.phase != PH_A_ON ##1 !output_a_oe || output_a_o
        == $past(state_reg.out_a_invert) || $past(ovr_on))
        else $error("A not cut on falling edge");
    hold_keep_a: assert property (state_reg.hold && !state_reg.shutdown_flag && !rise_ev
        |=> state_reg.hold) else $error("override dropped before rising edge"); // R8
    polarity_b_a: assert property (!ovr_on && state_reg.unit_enable // R12
        && state_reg.out_b_enable && state_reg.phase == PH_B_ON
        |=> output_b_oe && output_b_o == !$past(state_reg.out_b_invert))
        else $error("B polarity wrong");
endmodule : cwu_top
`default_nettype wire

// [verification/cwu_gate_model.sv]
// gate driver pair on the two output pins, flags overlap
`timescale 1ns/1ps
`default_nettype none
module cwu_gate_model (
    input  wire logic mclk,    // unit clock
    input  wire logic a_o,     // pin A level
    input  wire logic a_oe,    // pin A driven
    input  wire logic b_o,     // pin B level
    input  wire logic b_oe,    // pin B driven
    input  wire logic a_low,   // A switch turns on at a low pin
    input  wire logic b_low,   // B switch turns on at a low pin
    output logic      a_gate,  // gate A as seen on wire
    output logic      b_gate,  // gate B as seen on wire
    output logic      overlap  // both switches on
);
    // a released pin has no pull: show a changing level, not the last one
    always_ff @(posedge mclk) begin
        a_gate <= a_oe ? a_o : ~a_gate;
        b_gate <= b_oe ? b_o : ~b_gate;
    end
    // an inverted output turns its switch on at a low level
    assign overlap = a_oe & b_oe & (a_o ^ a_low) & (b_o ^ b_low);
endmodule : cwu_gate_model
`default_nettype wire

// [verification/cwu_top_tb.sv]
// self-checking bench for the complementary waveform unit
`timescale 1ns/1ps
`default_nettype none
module cwu_top_tb;
    import cwu_pkg::*;
    logic mclk = 0, srst = 1, rd_r = 0, wr_r = 0;
    logic [4:0] addr = 0;
    logic [31:0] wdat = 0, rdata, d;
    logic wreq, a_o, a_oe, b_o, b_oe, keep, ag, bg, ovl;
    logic cmp1 = 0, cmp2 = 0, nco = 0, cell1 = 0, cell2 = 0, flt_n = 1;
    logic pa_low = 0, pb_low = 0;
    logic [3:0] pwm = 0;
    int errors = 0, num_checks = 0, cycles = 0;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
    always #20 mclk = ~mclk;
    cwu_top #(.FAST_DIV(1)) DUT (.mclk(mclk), .srst(srst), .avs_address(addr),
        .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wdat),
        .avs_byteenable(4'h1), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .comparator_one_output(cmp1), .comparator_two_output(cmp2),
        .pulse_width_outputs(pwm), .numeric_oscillator_output(nco),
        .logic_cell_one_output(cell1), .logic_cell_two_output(cell2),
        .external_fault_pin_n(flt_n), .output_a_o(a_o), .output_a_oe(a_oe),
        .output_b_o(b_o), .output_b_oe(b_oe), .fast_osc_keep(keep));
    cwu_gate_model gm (.mclk(mclk), .a_o(a_o), .a_oe(a_oe), .b_o(b_o),
        .b_oe(b_oe), .a_low(pa_low), .b_low(pb_low), .a_gate(ag), .b_gate(bg),
        .overlap(ovl));
    task automatic summarize;
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // a hang counts as a mismatch; overlap of both switches is never allowed
    always @(posedge mclk) begin
        cycles++;
        if (ovl === 1'b1) `CHK(ovl, 1'b0)
        if (cycles > 20000) begin
            errors++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdat <= {24'h00_0000, v};
        if (w) wr_r <= 1'b1;
        else rd_r <= 1'b1;
        do @(posedge mclk); while (wreq !== 1'b0);
        d = rdata;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(d, {24'h00_0000, e})
    endtask : rd
    task automatic pins(input logic ea, input logic eb);
        `CHK({a_o, b_o}, {ea, eb})
    endtask : pins
    task automatic set_src(input int c, input logic v);
        case (c)
            0: cmp2 <= v;
            1: cmp1 <= v;
            6: nco <= v;
            7: cell1 <= v;
            default: pwm[c-2] <= v;
        endcase
    endtask : set_src
    initial begin
        cyc(12);
        srst <= 1'b0;
        rd(OFS_MAIN, 8'h00);
        rd(OFS_OVERRIDE, 8'h00);
        rd(OFS_SHUTDOWN, 8'h00);
        rd(OFS_RISE_DB, 8'h00);
        rd(5'h18, 8'h00);
        bus(1'b1, OFS_RISE_DB, 8'h05);
        bus(1'b1, OFS_FALL_DB, 8'h06);
        bus(1'b1, OFS_SHUTDOWN, 8'h82);
        bus(1'b1, OFS_OVERRIDE, 8'hE2);
        bus(1'b1, OFS_MAIN, 8'hE0);
        cyc(3);
        `CHK({a_oe, b_oe}, 2'b11)
        pins(1'b0, 1'b1);
        flt_n <= 1'b0;
        cyc(5);
        bus(1'b1, OFS_SHUTDOWN, 8'h02);
        rd(OFS_SHUTDOWN, 8'h82);
        flt_n <= 1'b1;
        cyc(5);
        bus(1'b1, OFS_SHUTDOWN, 8'h02);
        rd(OFS_SHUTDOWN, 8'h02);
        cyc(3);
        pins(1'b0, 1'b1);
        pwm[0] <= 1'b1;
        cyc(7);
        pins(1'b0, 1'b0);
        cyc(4);
        pins(1'b1, 1'b0);
        pwm[0] <= 1'b0;
        cyc(8);
        pins(1'b0, 1'b0);
        cyc(4);
        pins(1'b0, 1'b1);
        bus(1'b1, OFS_MAIN, 8'hF0);
        @(posedge mclk);
        pb_low <= 1'b1;
        cyc(1);
        `CHK(b_o, 1'b0)
        bus(1'b1, OFS_SHUTDOWN, 8'h44);
        cmp1 <= 1'b1;
        cyc(5);
        rd(OFS_SHUTDOWN, 8'hC4);
        pins(1'b0, 1'b1);
        bus(1'b1, OFS_OVERRIDE, 8'h42);
        cyc(2);
        `CHK({a_oe, a_o, b_oe}, 3'b100)
        cmp1 <= 1'b0;
        cyc(5);
        rd(OFS_SHUTDOWN, 8'h44);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, OFS_OVERRIDE, 8'hE0 | c[7:0]);
            set_src(c, 1'b1);
            cyc(5);
            bus(1'b0, OFS_STATUS, 8'h00);
            `CHK(d[0], 1'b1)
            set_src(c, 1'b0);
            cyc(5);
            bus(1'b0, OFS_STATUS, 8'h00);
            `CHK(d[0], 1'b0)
        end
        bus(1'b1, OFS_MAIN, 8'hC0);
        @(posedge mclk);
        pb_low <= 1'b0;
        cyc(1);
        `CHK({a_oe, b_oe}, 2'b01)
        bus(1'b1, OFS_MAIN, 8'h60);
        cyc(2);
        `CHK({a_oe, b_oe}, 2'b00)
        bus(1'b1, OFS_MAIN, 8'h81);
        cell1 <= 1'b1;
        cyc(5);
        `CHK(keep, 1'b1)
        bus(1'b1, OFS_MAIN, 8'h80);
        cyc(3);
        `CHK(keep, 1'b0)
        summarize();
    end
endmodule : cwu_top_tb
`default_nettype wire
